// [hw/ttc_op_if.sv]
// Lookup path between the controller and the operating point table
interface ttc_op_if #(parameter int IW = 2);
   logic [IW-1:0] freq_idx;
   logic [IW-1:0] vid_idx;
   logic [7:0] ratio;
   logic [7:0] vid;
   modport ctrl (output freq_idx, output vid_idx, input ratio, input vid);
   modport lookup (input freq_idx, input vid_idx, output ratio, output vid);
endinterface

// [hw/ttc_op_table.sv]
// Operating point table: frequency ratio and voltage-ID per point, registered read
module ttc_op_table
   import ttc_pkg::*;
#(
   parameter int NPTS = 4,
   parameter int IW = 2
) (
   input wire logic clk,
   input wire logic arst_n,
   ttc_op_if.lookup op
);
   if (NPTS < 2 || NPTS > (1 << IW)) begin : g_bad_param
      $error("ttc_op_table: NPTS must be at least 2 and fit the index width");
   end

   // Point 0 is the normal point; each deeper point is one ratio step and one code lower
   function automatic logic [7:0] ratio_of(input logic [IW-1:0] i);
      ratio_of = RATIO_TOP - RATIO_STEP * 8'(i);
   endfunction

   function automatic logic [7:0] vid_of(input logic [IW-1:0] i);
      vid_of = VID_TOP - 8'(i);
   endfunction

   wire logic [7:0] rd_ratio = ratio_of(op.freq_idx);
   wire logic [7:0] rd_vid = vid_of(op.vid_idx);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         op.ratio <= RATIO_TOP;
         op.vid <= VID_TOP;
      end else begin
         op.ratio <= rd_ratio;
         op.vid <= rd_vid;
      end
   end
endmodule

// [hw/ttc_pkg.sv]
// Constants shared by the thermal throttle control block
package ttc_pkg;
   localparam int CLK_MHZ = 100;
   localparam int CNT_W = 12;
   localparam int RATIO_W = 8;
   localparam int VID_W = 8;
   localparam int DUTY_W = 64;
   // Clock modulation timing
   localparam int MOD_PERIOD_US = 32;
   localparam int MOD_PERIOD_CYC = MOD_PERIOD_US * CLK_MHZ;
   localparam int TM_ON_EIGHTHS = 3;
   localparam int TM_ON_CYC = (MOD_PERIOD_CYC * TM_ON_EIGHTHS) / 8;
   localparam int DUTY_UNIT_CYC = MOD_PERIOD_CYC / 16;
   // Operating point transitions
   localparam int FREQ_SETTLE_NS = 2000;
   localparam int FREQ_SETTLE_CYC = (FREQ_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int VID_STEP_NS = 1000;
   localparam int VID_STEP_CYC = (VID_STEP_NS * CLK_MHZ + 999) / 1000;
   // Duty control register fields
   localparam int DUTY_FORCE_BIT = 4;
   localparam int DUTY_SEL_LSB = 0;
   localparam int DUTY_SEL_W = 4;
   localparam logic [4:0] DUTY_RESET = 5'h00;
   localparam logic [3:0] DUTY_RESERVED_SUB = 4'h8;
   // Default operating point table shape and temperature target
   localparam logic [7:0] RATIO_TOP = 8'h20;
   localparam logic [7:0] RATIO_STEP = 8'h02;
   localparam logic [7:0] VID_TOP = 8'h80;
   localparam logic [7:0] TEMP_TARGET_DEF = 8'h5A;

   typedef enum logic [2:0] {
      TTC_NORMAL = 3'b000,
      TTC_FDOWN = 3'b001,
      TTC_VDOWN = 3'b010,
      TTC_MIN = 3'b011,
      TTC_VUP = 3'b100,
      TTC_FUP = 3'b101
   } ttc_state_t;
endpackage

// [hw/ttc_throttle.sv]
// Thermal throttle control: frequency/voltage stepping, clock modulation, hot pin
module ttc_throttle
   import ttc_pkg::*;
#(
   parameter int NPTS = 4,
   parameter int HYST_CYC = 1000,
   parameter logic [7:0] TEMP_TARGET = TEMP_TARGET_DEF
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic over_threshold,
   input wire logic monitor_enable,
   input wire logic hot_indicator_n_in,
   output logic hot_indicator_n_out,
   output logic hot_indicator_n_oe,
   input wire logic duty_wr,
   input wire logic [DUTY_W-1:0] duty_wdata,
   output logic [DUTY_W-1:0] duty_rdata,
   output logic [7:0] temp_target,
   input wire logic irq_on_assert_en,
   input wire logic irq_on_deassert_en,
   output logic hot_irq,
   output logic thermal_control_circuit_active,
   output logic [RATIO_W-1:0] freq_ratio,
   output logic [VID_W-1:0] serial_voltage_id,
   output logic core_clk_en
);
   localparam int IW = (NPTS > 2) ? $clog2(NPTS) : 1;
   localparam logic [IW-1:0] MIN_IDX = IW'(NPTS - 1);
   localparam int HW = $clog2(HYST_CYC + 1);

   if (NPTS < 2 || NPTS > 16 || HYST_CYC < 1) begin : g_bad_param
      $error("ttc_throttle: NPTS must be 2..16 and HYST_CYC at least 1");
   end

   ttc_op_if #(.IW(IW)) op ();

   ttc_op_table #(.NPTS(NPTS), .IW(IW)) u_table (
      .clk(clk),
      .arst_n(arst_n),
      .op(op)
   );

   // Hot pin synchroniser; only the second stage is read
   logic hot_s1;
   logic hot_s2;
   logic [1:0] own_drive_hist;
   logic hot_lvl_prev;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hot_s1 <= 1'b1;
         hot_s2 <= 1'b1;
      end else begin
         hot_s1 <= hot_indicator_n_in;
         hot_s2 <= hot_s1;
      end
   end

   // Our own drive shows up on the pin two cycles late; mask it so it is not seen as external
   wire logic own_drive = hot_indicator_n_oe | (|own_drive_hist);
   wire logic ext_hot = monitor_enable & ~hot_s2 & ~own_drive;
   wire logic therm_hot = monitor_enable & over_threshold;
   wire logic pin_hot = ~hot_s2;

   // Hysteresis counter reloads while over threshold (not on external hot) and runs down once cool
   logic [HW-1:0] hyst_cnt;
   wire logic hyst_done = (hyst_cnt == '0);
   wire logic release_ok = ~therm_hot & hyst_done & ~ext_hot;
   wire logic next_active = (therm_hot | ext_hot) ? 1'b1
                          : (release_ok ? 1'b0 : thermal_control_circuit_active);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hyst_cnt <= '0;
         thermal_control_circuit_active <= 1'b0;
         hot_indicator_n_oe <= 1'b0;
         hot_indicator_n_out <= 1'b1;
         own_drive_hist <= 2'b00;
         hot_lvl_prev <= 1'b0;
         hot_irq <= 1'b0;
         temp_target <= TEMP_TARGET_DEF;
      end else begin
         hyst_cnt <= therm_hot ? HW'(HYST_CYC) : (hyst_done ? hyst_cnt : hyst_cnt - 1'b1);
         thermal_control_circuit_active <= next_active;
         hot_indicator_n_oe <= therm_hot;
         hot_indicator_n_out <= 1'b0;
         own_drive_hist <= {own_drive_hist[0], hot_indicator_n_oe};
         hot_lvl_prev <= pin_hot;
         hot_irq <= (pin_hot & ~hot_lvl_prev & irq_on_assert_en)
                  | (~pin_hot & hot_lvl_prev & irq_on_deassert_en);
         temp_target <= TEMP_TARGET;
      end
   end

   // Operating point sequencer; the core keeps executing throughout
   ttc_state_t state;
   ttc_state_t next_state;
   logic [CNT_W-1:0] step_cnt;
   logic [CNT_W-1:0] next_step_cnt;
   logic [IW-1:0] f_idx;
   logic [IW-1:0] v_idx;
   logic [IW-1:0] next_f_idx;
   logic [IW-1:0] next_v_idx;
   wire logic step_due = (step_cnt == '0);
   wire logic [CNT_W-1:0] cnt_dec = step_due ? step_cnt : step_cnt - 1'b1;

   always_comb begin
      next_state = state;
      next_step_cnt = cnt_dec;
      next_f_idx = f_idx;
      next_v_idx = v_idx;
      unique case (state)
         TTC_NORMAL: begin
            if (thermal_control_circuit_active) begin
               next_f_idx = MIN_IDX;
               next_step_cnt = CNT_W'(FREQ_SETTLE_CYC);
               next_state = TTC_FDOWN;
            end
         end
         TTC_FDOWN: begin
            if (step_due) begin
               next_step_cnt = CNT_W'(VID_STEP_CYC);
               next_state = TTC_VDOWN;
            end
         end
         TTC_VDOWN: begin
            if (step_due) begin
               next_step_cnt = CNT_W'(VID_STEP_CYC);
               if (v_idx != MIN_IDX) begin
                  next_v_idx = v_idx + 1'b1;
               end else begin
                  next_state = TTC_MIN;
               end
            end
         end
         TTC_MIN: begin
            if (!thermal_control_circuit_active) begin
               next_step_cnt = CNT_W'(VID_STEP_CYC);
               next_state = TTC_VUP;
            end
         end
         TTC_VUP: begin
            if (thermal_control_circuit_active) begin
               next_state = TTC_VDOWN;
            end else if (step_due) begin
               next_step_cnt = CNT_W'(VID_STEP_CYC);
               if (v_idx != '0) begin
                  next_v_idx = v_idx - 1'b1;
               end else begin
                  next_f_idx = '0;
                  next_step_cnt = CNT_W'(FREQ_SETTLE_CYC);
                  next_state = TTC_FUP;
               end
            end
         end
         TTC_FUP: begin
            if (thermal_control_circuit_active) begin
               next_f_idx = MIN_IDX;
               next_step_cnt = CNT_W'(FREQ_SETTLE_CYC);
               next_state = TTC_FDOWN;
            end else if (step_due) begin
               next_state = TTC_NORMAL;
            end
         end
         default: begin
            next_state = TTC_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= TTC_NORMAL;
         step_cnt <= '0;
         f_idx <= '0;
         v_idx <= '0;
      end else begin
         state <= next_state;
         step_cnt <= next_step_cnt;
         f_idx <= next_f_idx;
         v_idx <= next_v_idx;
      end
   end

   assign op.freq_idx = f_idx;
   assign op.vid_idx = v_idx;
   assign freq_ratio = op.ratio;
   assign serial_voltage_id = op.vid;

   // Duty control register: only force bit and duty field are stored
   logic [4:0] duty_ctl;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         duty_ctl <= DUTY_RESET;
         duty_rdata <= '0;
      end else begin
         if (duty_wr) begin
            duty_ctl <= duty_wdata[4:0];
         end
         duty_rdata <= {{(DUTY_W - 5){1'b0}}, duty_ctl};
      end
   end

   // Modulation runs from thermal control in the minimum state or from the software force bit; external hot alone never modulates
   wire logic mod_thermal = thermal_control_circuit_active & (state == TTC_MIN)
                          & ~ext_hot;
   wire logic sw_force = duty_ctl[DUTY_FORCE_BIT];
   wire logic [3:0] sw_duty = duty_ctl[DUTY_SEL_LSB +: DUTY_SEL_W];
   // Code 0 is reserved; it is run as half duty rather than stopping the core outright
   wire logic [3:0] sw_duty_eff = (sw_duty == 4'h0) ? DUTY_RESERVED_SUB : sw_duty;
   wire logic use_tm_duty = mod_thermal | (sw_force & thermal_control_circuit_active);
   wire logic [CNT_W-1:0] on_cyc = use_tm_duty ? CNT_W'(TM_ON_CYC)
                                 : CNT_W'(DUTY_UNIT_CYC) * CNT_W'(sw_duty_eff);
   wire logic mod_run = mod_thermal | sw_force;

   // Period counts core clock cycles of the fixed reference, not the scaled ratio
   logic [CNT_W-1:0] mod_cnt;
   wire logic mod_wrap = (mod_cnt == CNT_W'(MOD_PERIOD_CYC - 1));
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mod_cnt <= '0;
         core_clk_en <= 1'b1;
      end else begin
         mod_cnt <= (!mod_run || mod_wrap) ? '0 : mod_cnt + 1'b1;
         // Only core clocks are gated; snoop and interrupt logic stay clocked
         core_clk_en <= !mod_run || (mod_cnt < on_cyc);
      end
   end
endmodule

// [test/ttc_throttle_asserts.sv]
// Port-level assertions for the thermal throttle control block
module ttc_throttle_asserts
   import ttc_pkg::*;
#(
   parameter int NPTS = 4,
   parameter int HYST_CYC = 1000
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic over_threshold,
   input wire logic monitor_enable,
   input wire logic hot_indicator_n_in,
   input wire logic hot_indicator_n_out,
   input wire logic hot_indicator_n_oe,
   input wire logic duty_wr,
   input wire logic [DUTY_W-1:0] duty_wdata,
   input wire logic [DUTY_W-1:0] duty_rdata,
   input wire logic hot_irq,
   input wire logic thermal_control_circuit_active,
   input wire logic [RATIO_W-1:0] freq_ratio,
   input wire logic [VID_W-1:0] serial_voltage_id,
   input wire logic core_clk_en
);
   localparam logic [7:0] RMIN = RATIO_TOP - 8'(RATIO_STEP * (NPTS - 1));
   localparam logic [7:0] VMIN = VID_TOP - 8'(NPTS - 1);
   wire logic act = thermal_control_circuit_active;
   wire logic [7:0] vid = serial_voltage_id;
   logic [15:0] cool_cnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Cycles since the die was last over threshold; saturates so long idle runs stay valid
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) cool_cnt <= 16'h0000;
      else if (over_threshold) cool_cnt <= 16'h0000;
      else if (cool_cnt != 16'hFFFF) cool_cnt <= cool_cnt + 16'h0001;
   end
   sequence s_hot; monitor_enable && over_threshold; endsequence
   sequence s_ext_held; (monitor_enable && !hot_indicator_n_in && !hot_indicator_n_oe)[*8]; endsequence
   sequence s_wr_land; ##2 duty_rdata[4:0] == $past(duty_wdata[4:0], 2); endsequence
   property p_act; s_hot |-> ##[1:2] act; endproperty
   property p_pin; s_hot |-> ##[1:3] hot_indicator_n_oe; endproperty
   property p_pin_lvl; hot_indicator_n_oe |-> !hot_indicator_n_out; endproperty
   property p_step; $changed(vid) |-> vid == $past(vid) + 8'h01 || vid == $past(vid) - 8'h01;
   endproperty
   property p_vf; $changed(vid) |-> freq_ratio == RMIN; endproperty
   property p_fv; $changed(freq_ratio) && freq_ratio > $past(freq_ratio) |-> vid == VID_TOP;
   endproperty
   property p_gate; !core_clk_en |-> duty_rdata[4] || $past(duty_rdata[4])
      || ((act || $past(act)) && freq_ratio == RMIN && vid == VMIN); endproperty
   property p_release; $fell(act) |-> cool_cnt >= 16'(HYST_CYC - 2)
      && (hot_indicator_n_in || hot_indicator_n_oe); endproperty
   property p_wr; duty_wr |-> s_wr_land; endproperty
   property p_rsvd; duty_rdata[DUTY_W-1:5] == '0; endproperty
   property p_irq1; hot_irq |=> !hot_irq; endproperty
   property p_irq_src; hot_irq |-> $past(hot_indicator_n_in, 2) != $past(hot_indicator_n_in, 5);
   endproperty
   property p_ext; s_ext_held |-> act; endproperty
   a_act: assert property (p_act) else $error("active late");
   a_pin: assert property (p_pin) else $error("pin not driven");
   a_pin_lvl: assert property (p_pin_lvl) else $error("pin driven high");
   a_step: assert property (p_step) else $error("voltage code jumped");
   a_vf: assert property (p_vf) else $error("voltage moved off min ratio");
   a_fv: assert property (p_fv) else $error("ratio rose before voltage");
   a_gate: assert property (p_gate) else $error("clock gated without cause");
   a_release: assert property (p_release) else $error("early release");
   a_wr: assert property (p_wr) else $error("write not stored");
   a_rsvd: assert property (p_rsvd) else $error("upper bits set");
   a_irq1: assert property (p_irq1) else $error("irq too long");
   a_irq_src: assert property (p_irq_src) else $error("irq without pin edge");
   a_ext: assert property (p_ext) else $error("external hot ignored");
endmodule
bind ttc_throttle ttc_throttle_asserts #(.NPTS(NPTS), .HYST_CYC(HYST_CYC)) u_asserts (.*);

// [test/ttc_throttle_tb.sv]
// Self-checking bench for the thermal throttle control block
module ttc_throttle_tb
   import ttc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HYST = 50;
   localparam logic [7:0] RMIN = RATIO_TOP - 8'(RATIO_STEP * 3);
   localparam logic [7:0] VMIN = VID_TOP - 8'h03;
   logic clk = 0, arst_n = 0, over = 0, mon_en = 0, ext_n = 1, duty_wr = 0, irq_a = 0, irq_d = 0;
   logic [DUTY_W-1:0] wdata = '0;
   logic [DUTY_W-1:0] rdata;
   logic oe, out_n, hot_irq, act, clk_en;
   logic [7:0] tgt, ratio, vid, vout;
   int err_total = 0, n_tests = 0, cyc = 0, irq_cnt = 0, bad_steps;
   // Open-drain pin with pull-up: either party may pull it low
   wire logic pin_n = ext_n & (oe ? out_n : 1'b1);
   ttc_throttle #(.HYST_CYC(HYST)) uut (.clk(clk), .arst_n(arst_n), .over_threshold(over),
      .monitor_enable(mon_en), .hot_indicator_n_in(pin_n), .hot_indicator_n_out(out_n),
      .hot_indicator_n_oe(oe), .duty_wr(duty_wr), .duty_wdata(wdata), .duty_rdata(rdata),
      .temp_target(tgt), .irq_on_assert_en(irq_a), .irq_on_deassert_en(irq_d),
      .hot_irq(hot_irq), .thermal_control_circuit_active(act), .freq_ratio(ratio),
      .serial_voltage_id(vid), .core_clk_en(clk_en));
   ttc_vr_model vr (.clk(clk), .arst_n(arst_n), .vid(vid), .vout(vout), .bad_steps(bad_steps));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (hot_irq === 1'b1) irq_cnt <= irq_cnt + 1;
      if (cyc == 80000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_en(input logic lvl, output int n);
      n = 0;
      while (clk_en !== lvl && n < 8000) begin
         tick(1);
         n++;
      end
   endtask
   task automatic wait_vid(input logic [7:0] v);
      int n;
      n = 0;
      while (vid !== v && n < 3000) begin
         tick(1);
         n++;
      end
   endtask
   // Skips any partial phase left by a duty change, then measures one low and one run phase
   task automatic mod_chk(input int hi_exp, input string what);
      int n, lo, hi;
      wait_en(1'b1, n);
      wait_en(1'b0, n);
      wait_en(1'b1, lo);
      wait_en(1'b0, hi);
      chk(what, 64'(hi_exp), 64'(hi));
      chk(what, 64'(MOD_PERIOD_CYC - hi_exp), 64'(lo));
   endtask
   task automatic wr(input logic [63:0] d);
      duty_wr = 1'b1;
      wdata = d;
      tick(1);
      duty_wr = 1'b0;
      tick(2);
   endtask
   task automatic t_reset();
      chk("rdata", 0, rdata);
      chk("target", 64'(TEMP_TARGET_DEF), 64'(tgt));
      chk("ratio", 64'(RATIO_TOP), 64'(ratio));
      chk("clk_en", 1, 64'(clk_en));
   endtask
   task automatic t_thermal();
      over = 1'b1;
      tick(5);
      chk("idle_act", 0, 64'(act));
      mon_en = 1'b1;
      tick(3);
      chk("act", 1, 64'(act));
      chk("pin", 0, 64'(pin_n));
      wait_vid(VMIN);
      chk("ratio_min", 64'(RMIN), 64'(ratio));
      mod_chk(TM_ON_CYC, "tm_duty");
      wr(64'h0000_0000_0000_0013);
      mod_chk(TM_ON_CYC, "override");
      wr(64'h0000_0000_0000_0000);
      over = 1'b0;
      tick(HYST - 5);
      chk("hyst_act", 1, 64'(act));
      wait_vid(VID_TOP);
      tick(300);
      chk("act_off", 0, 64'(act));
      chk("ratio_top", 64'(RATIO_TOP), 64'(ratio));
      chk("vr", 64'(VID_TOP), 64'(vout));
      chk("vr_steps", 0, 64'(bad_steps));
   endtask
   task automatic t_forced();
      logic [3:0] codes[4] = '{4'h1, 4'h8, 4'hF, 4'h0};
      int on_exp;
      foreach (codes[i]) begin
         wr({59'h7FF_FFFF_FFFF_FFFF, 1'b1, codes[i]});
         chk("duty_rd", {59'h0, 1'b1, codes[i]}, rdata);
         // Reserved code 0 is expected to run at the substitute duty
         on_exp = (codes[i] == 4'h0) ? int'(DUTY_RESERVED_SUB) : int'(codes[i]);
         mod_chk(on_exp * DUTY_UNIT_CYC, "sw_duty");
      end
      wr(64'h0000_0000_0000_0000);
      tick(3);
      chk("clk_run", 1, 64'(clk_en));
   endtask
   task automatic t_external();
      int n, i0;
      i0 = irq_cnt;
      irq_a = 1'b1;
      ext_n = 1'b0;
      tick(10);
      chk("ext_act", 1, 64'(act));
      wait_vid(VMIN);
      chk("ext_ratio", 64'(RMIN), 64'(ratio));
      wait_en(1'b0, n);
      chk("ext_no_mod", 1, 64'(clk_en));
      chk("ext_held", 1, 64'(act));
      irq_d = 1'b1;
      ext_n = 1'b1;
      tick(HYST + 10);
      chk("ext_off", 0, 64'(act));
      chk("irq", 2, 64'(irq_cnt - i0));
      wait_vid(VID_TOP);
   endtask
   initial begin
      tick(16);
      arst_n = 1'b1;
      tick(2);
      t_reset();
      t_thermal();
      t_forced();
      t_external();
      end_sim();
   end
endmodule

// [test/ttc_vr_model.sv]
// Behavioural core regulator that follows the voltage-ID code after a slew delay
module ttc_vr_model
   import ttc_pkg::*;
#(
   parameter int SLEW = 60
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] vid,
   output logic [7:0] vout,
   output int bad_steps
);
   logic [7:0] prev;
   int dwell;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev <= VID_TOP;
         vout <= VID_TOP;
         dwell <= 0;
         bad_steps <= 0;
      end else if (vid != prev) begin
         // Every change is followed; any change other than a single-entry step is counted as a regulator fault
         if (vid != prev + 8'h01 && vid != prev - 8'h01) bad_steps <= bad_steps + 1;
         prev <= vid;
         dwell <= SLEW;
      end else if (dwell > 0) begin
         dwell <= dwell - 1;
      end else begin
         vout <= prev;
      end
   end
endmodule
